// >>> fsf_pkg.sv
// What this block does
// - Ready flag low while command runs
// - Lock violation sets flag, status read clears
// - Bad command or key sets flag, read clears
// - Security bit reads one when active
// - Page blank result reads one when erased
// - Read-only three-bit size code, 32..1024 KB
// - Status bits 31..16 show region locks
// - Fuse reads zero programmed, one erased
// - High fuse register only for >32 fuses
// - Thirty-two fuses in the low register
// - Chip erase sets every fuse erased
// - Shipped low fuse value 0xfff7ffff
// - Brown-out enable field encoding
// - Bit 26 enables brown-out hysteresis
// - Six-bit threshold, all ones never triggers
// - Boot protect field defaults 011, 8 KB
// - Privileged fetch lock fuse defaults one
// - Region lock fuses default all ones
// - Fuse bits 31..29 reserved
// - Reset: locks from fuses, rest zero
package fsf_pkg;

  localparam int          ADDR_W          = 5;
  localparam int          DATA_W          = 32;
  localparam int          FUSE_IDX_W      = 6;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [4:0]  ADDR_STATUS     = 5'h08;
  localparam logic [4:0]  ADDR_FUSE_HIGH  = 5'h0c;
  localparam logic [4:0]  ADDR_FUSE_LOW   = 5'h10;

  // ---------------------------------------------------------------
  // Status field positions
  // ---------------------------------------------------------------
  localparam int          ST_IDLE_BIT     = 0;
  localparam int          ST_LOCKERR_BIT  = 2;
  localparam int          ST_CMDERR_BIT   = 3;
  localparam int          ST_SECURE_BIT   = 4;
  localparam int          ST_BLANK_BIT    = 5;
  localparam int          ST_SIZE_LSB     = 13;
  localparam int          ST_SIZE_W       = 3;
  localparam int          ST_LOCK_LSB     = 16;
  localparam int          NUM_REGIONS     = 16;

  // ---------------------------------------------------------------
  // Fuse field positions in the low register
  // ---------------------------------------------------------------
  localparam int          FU_LOCK_LSB     = 0;
  localparam int          FU_FETCH_BIT    = 16;
  localparam int          FU_BOOT_LSB     = 17;
  localparam int          FU_BOOT_W       = 3;
  localparam int          FU_BOD_LVL_LSB  = 20;
  localparam int          FU_BOD_LVL_W    = 6;
  localparam int          FU_BOD_HYST_BIT = 26;
  localparam int          FU_BOD_EN_LSB   = 27;
  localparam int          FU_BOD_EN_W     = 2;

  localparam logic [31:0] FUSE_SHIPPED    = 32'hfff7ffff;
  localparam logic [31:0] ZERO_WORD       = 32'h00000000;
  localparam logic [2:0]  SIZE_256K       = 3'h3;

  // Size codes
  typedef enum logic [2:0] {
    FSF_SZ_32K, FSF_SZ_64K, FSF_SZ_128K, FSF_SZ_256K,
    FSF_SZ_384K, FSF_SZ_512K, FSF_SZ_768K, FSF_SZ_1024K
  } fsf_size_t;

  // Brown-out enable encodings
  typedef enum logic [1:0] {
    FSF_BOD_OFF, FSF_BOD_RESET, FSF_BOD_NORESET, FSF_BOD_OFF2
  } fsf_bod_t;

endpackage : fsf_pkg

// >>> fsf_status_fuse.sv
`timescale 1ns/1ps
module fsf_status_fuse #(
  parameter int         NUM_FUSES = 32,
  parameter logic [2:0] SIZE_CODE = fsf_pkg::SIZE_256K
) (
  input  wire logic                            sys_clk,
  input  wire logic                            sys_rst,
  // Avalon-MM slave
  input  wire logic [fsf_pkg::ADDR_W-1:0]      avs_address,
  input  wire logic                            avs_read,
  input  wire logic                            avs_write,
  input  wire logic [fsf_pkg::DATA_W-1:0]      avs_writedata,
  output logic      [fsf_pkg::DATA_W-1:0]      avs_readdata,
  output logic                                 avs_waitrequest,
  // Command engine, same clock
  input  wire logic                            cmd_busy,
  input  wire logic                            locked_write_attempt,
  input  wire logic                            bad_command_event,
  input  wire logic                            security_active,
  input  wire logic                            page_blank_in,
  input  wire logic                            fuse_write_en,
  input  wire logic [fsf_pkg::FUSE_IDX_W-1:0]  fuse_write_idx,
  input  wire logic                            fuse_write_val,
  input  wire logic                            fuse_erase_all,
  // Chip erase request from the debug port, asynchronous
  input  wire logic                            jtag_chip_erase,
  // Decoded fuse fields
  output logic      [1:0]                      brownout_enable_fuses,
  output logic                                 brownout_hysteresis_fuse,
  output logic      [5:0]                      brownout_threshold_fuses,
  output logic      [2:0]                      boot_area_protect_fuses,
  output logic                                 privileged_fetch_lock_fuse,
  output logic      [15:0]                     region_locked_status
);
  import fsf_pkg::*;

  // ---------------------------------------------------------------
  // Chip erase synchroniser and edge detect
  // ---------------------------------------------------------------
  logic erase_s1_reg;
  logic erase_s2_reg;
  logic erase_s3_reg;
  logic erase_s1_next;
  logic erase_s2_next;
  logic erase_s3_next;
  logic chip_erase;

  always_comb begin
    erase_s1_next = jtag_chip_erase;
    erase_s2_next = erase_s1_reg;
    erase_s3_next = erase_s2_reg;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      erase_s1_reg <= 1'b0;
      erase_s2_reg <= 1'b0;
      erase_s3_reg <= 1'b0;
    end else begin
      erase_s1_reg <= erase_s1_next;
      erase_s2_reg <= erase_s2_next;
      erase_s3_reg <= erase_s3_next;
    end
  end

  // Rising edge only, so a held request erases once
  assign chip_erase = erase_s2_reg & ~erase_s3_reg;

  // ---------------------------------------------------------------
  // Fuse storage
  // ---------------------------------------------------------------
  // Nonvolatile cells are modelled as flip-flops that come up at the
  // shipped value; a real array would load its contents instead.
  logic [63:0] fuse_reg;
  logic [63:0] fuse_next;

  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++) begin : g_fuse
      if (gi < NUM_FUSES) begin : g_cell
        always_comb begin
          fuse_next[gi] = fuse_reg[gi];
          if (chip_erase || fuse_erase_all) begin
            fuse_next[gi] = 1'b1;
          end else if (fuse_write_en && (fuse_write_idx == FUSE_IDX_W'(gi))) begin
            fuse_next[gi] = fuse_write_val;
          end
        end
        always_ff @(posedge sys_clk or posedge sys_rst) begin
          if (sys_rst) begin
            if (gi < 32) begin
              fuse_reg[gi] <= FUSE_SHIPPED[gi % 32];
            end else begin
              fuse_reg[gi] <= 1'b1;
            end
          end else begin
            fuse_reg[gi] <= fuse_next[gi];
          end
        end
      end else begin : g_none
        // Unmapped fuse positions read zero
        always_comb begin
          fuse_next[gi] = 1'b0;
        end
        always_ff @(posedge sys_clk or posedge sys_rst) begin
          if (sys_rst) begin
            fuse_reg[gi] <= 1'b0;
          end else begin
            fuse_reg[gi] <= fuse_next[gi];
          end
        end
      end
    end
  endgenerate

  // Fuse fields straight off the storage flops; bits 31..29 have no
  // consumer and are only visible through the register.
  assign brownout_enable_fuses      = fuse_reg[FU_BOD_EN_LSB +: FU_BOD_EN_W];
  assign brownout_hysteresis_fuse   = fuse_reg[FU_BOD_HYST_BIT];
  assign brownout_threshold_fuses   = fuse_reg[FU_BOD_LVL_LSB +: FU_BOD_LVL_W];
  assign boot_area_protect_fuses    = fuse_reg[FU_BOOT_LSB +: FU_BOOT_W];
  assign privileged_fetch_lock_fuse = fuse_reg[FU_FETCH_BIT];

  // ---------------------------------------------------------------
  // Status state
  // ---------------------------------------------------------------
  logic        idle_reg;
  logic        lock_err_reg;
  logic        cmd_err_reg;
  logic        secure_reg;
  logic        blank_reg;
  logic [2:0]  size_reg;
  logic [15:0] locks_reg;
  logic        idle_next;
  logic        lock_err_next;
  logic        cmd_err_next;
  logic        secure_next;
  logic        blank_next;
  logic [2:0]  size_next;
  logic [15:0] locks_next;
  logic        status_read_done;

  always_comb begin
    idle_next     = ~cmd_busy;
    secure_next   = security_active;
    blank_next    = page_blank_in;
    size_next     = SIZE_CODE;
    locks_next    = ~fuse_next[FU_LOCK_LSB +: NUM_REGIONS];
    lock_err_next = lock_err_reg;
    cmd_err_next  = cmd_err_reg;
    // Only flags the master was shown are cleared, so an event taken
    // at the request edge is not lost; a new event still wins below.
    if (status_read_done) begin
      lock_err_next = lock_err_reg & ~rdata_reg[ST_LOCKERR_BIT];
      cmd_err_next  = cmd_err_reg & ~rdata_reg[ST_CMDERR_BIT];
    end
    if (locked_write_attempt) begin
      lock_err_next = 1'b1;
    end
    if (bad_command_event) begin
      cmd_err_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_reg     <= 1'b0;
      lock_err_reg <= 1'b0;
      cmd_err_reg  <= 1'b0;
      secure_reg   <= 1'b0;
      blank_reg    <= 1'b0;
      size_reg     <= 3'h0;
      locks_reg    <= ~FUSE_SHIPPED[FU_LOCK_LSB +: NUM_REGIONS];
    end else begin
      idle_reg     <= idle_next;
      lock_err_reg <= lock_err_next;
      cmd_err_reg  <= cmd_err_next;
      secure_reg   <= secure_next;
      blank_reg    <= blank_next;
      size_reg     <= size_next;
      locks_reg    <= locks_next;
    end
  end

  assign region_locked_status = locks_reg;

  // ---------------------------------------------------------------
  // Avalon-MM slave: one wait state on every access
  // ---------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        wait_reg;
  logic        wait_next;
  logic        req;

  assign req = avs_read | avs_write;

  always_comb begin
    status_word = ZERO_WORD;
    status_word[ST_IDLE_BIT]    = idle_reg;
    status_word[ST_LOCKERR_BIT] = lock_err_reg;
    status_word[ST_CMDERR_BIT]  = cmd_err_reg;
    status_word[ST_SECURE_BIT]  = secure_reg;
    status_word[ST_BLANK_BIT]   = blank_reg;
    status_word[ST_SIZE_LSB +: ST_SIZE_W]     = size_reg;
    status_word[ST_LOCK_LSB +: NUM_REGIONS]   = locks_reg;
  end

  // Read clears at the completing edge, the one where the master
  // sees waitrequest low, so a stalled read cannot lose an event.
  assign status_read_done = avs_read & ~wait_reg & (avs_address == ADDR_STATUS);

  always_comb begin
    wait_next  = 1'b1;
    rdata_next = rdata_reg;
    if (req && wait_reg) begin
      wait_next  = 1'b0;
      rdata_next = ZERO_WORD;
      if (avs_read) begin
        if (avs_address == ADDR_STATUS) begin
          rdata_next = status_word;
        end else if (avs_address == ADDR_FUSE_HIGH) begin
          rdata_next = fuse_reg[63:32];
        end else if (avs_address == ADDR_FUSE_LOW) begin
          rdata_next = fuse_reg[31:0];
        end else begin
          rdata_next = ZERO_WORD;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_reg  <= 1'b1;
      rdata_reg <= ZERO_WORD;
    end else begin
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = rdata_reg;

endmodule : fsf_status_fuse

// >>> fsf_status_fuse_chk.sv
`timescale 1ns/1ps
module fsf_status_fuse_chk
  import fsf_pkg::*;
#(
  parameter logic [2:0] SIZE_CODE = SIZE_256K
) (
  input wire logic                       sys_clk,
  input wire logic                       sys_rst,
  input wire logic [fsf_pkg::ADDR_W-1:0] avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [fsf_pkg::DATA_W-1:0] avs_readdata,
  input wire logic                       avs_waitrequest,
  input wire logic                       cmd_busy,
  input wire logic                       security_active,
  input wire logic                       page_blank_in,
  input wire logic [1:0]                 brownout_enable_fuses,
  input wire logic [5:0]                 brownout_threshold_fuses,
  input wire logic [2:0]                 boot_area_protect_fuses,
  input wire logic [15:0]                region_locked_status
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------
  // Read completions
  // ---------------------------------------------------------------
  wire st_done = avs_read && !avs_waitrequest && avs_address == ADDR_STATUS;
  wire lo_done = avs_read && !avs_waitrequest && avs_address == ADDR_FUSE_LOW;
  wire hi_done = avs_read && !avs_waitrequest && avs_address == ADDR_FUSE_HIGH;

  property p_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer timing wrong");
  // Status word is taken one cycle after its inputs were registered
  property p_ready;
    st_done |-> avs_readdata[ST_IDLE_BIT] == !$past(cmd_busy, 2);
  endproperty
  a_ready: assert property (p_ready) else $error("ready bit wrong");
  property p_secure;
    st_done |-> avs_readdata[ST_SECURE_BIT] == $past(security_active, 2);
  endproperty
  a_secure: assert property (p_secure) else $error("security bit wrong");
  property p_blank;
    st_done |-> avs_readdata[ST_BLANK_BIT] == $past(page_blank_in, 2);
  endproperty
  a_blank: assert property (p_blank) else $error("blank bit wrong");
  property p_size;
    st_done |-> avs_readdata[15:13] == SIZE_CODE && avs_readdata[12:6] == 7'h00;
  endproperty
  a_size: assert property (p_size) else $error("size field wrong");
  property p_high;
    hi_done |-> avs_readdata == ZERO_WORD;
  endproperty
  a_high: assert property (p_high) else $error("high fuse word not zero");
  property p_bod;
    lo_done |-> avs_readdata[28:27] == $past(brownout_enable_fuses);
  endproperty
  a_bod: assert property (p_bod) else $error("brownout enable mismatch");
  property p_lvl;
    lo_done |-> avs_readdata[25:20] == $past(brownout_threshold_fuses);
  endproperty
  a_lvl: assert property (p_lvl) else $error("threshold mismatch");
  property p_boot;
    lo_done |-> avs_readdata[19:17] == $past(boot_area_protect_fuses);
  endproperty
  a_boot: assert property (p_boot) else $error("boot protect mismatch");
  property p_lock;
    lo_done |-> avs_readdata[15:0] == ~$past(region_locked_status);
  endproperty
  a_lock: assert property (p_lock) else $error("lock status not inverse");
endmodule : fsf_status_fuse_chk

bind fsf_status_fuse fsf_status_fuse_chk #(.SIZE_CODE(SIZE_CODE)) u_fsf_status_fuse_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .cmd_busy(cmd_busy), .security_active(security_active), .page_blank_in(page_blank_in),
  .brownout_enable_fuses(brownout_enable_fuses),
  .brownout_threshold_fuses(brownout_threshold_fuses),
  .boot_area_protect_fuses(boot_area_protect_fuses),
  .region_locked_status(region_locked_status));

// >>> fsf_status_fuse_tb.sv
`timescale 1ns/1ps
module fsf_status_fuse_tb;
  import fsf_pkg::*;
  logic        sys_clk, sys_rst, avs_read, avs_write, cmd_busy, lwa, bce, sec, blank;
  logic        fw_en, fw_val, erase_all, jtag, hyst, fetch;
  logic [4:0]  avs_address;
  logic [5:0]  fw_idx, lvl;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic        avs_waitrequest;
  logic [1:0]  bod;
  logic [2:0]  boot;
  logic [15:0] locks;
  int          n_mismatch, checked;

  fsf_status_fuse u_fsf_status_fuse (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cmd_busy(cmd_busy), .locked_write_attempt(lwa),
    .bad_command_event(bce), .security_active(sec), .page_blank_in(blank),
    .fuse_write_en(fw_en), .fuse_write_idx(fw_idx), .fuse_write_val(fw_val),
    .fuse_erase_all(erase_all), .jtag_chip_erase(jtag), .brownout_enable_fuses(bod),
    .brownout_hysteresis_fuse(hyst), .brownout_threshold_fuses(lvl),
    .boot_area_protect_fuses(boot), .privileged_fetch_lock_fuse(fetch),
    .region_locked_status(locks));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task finish_test;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low
  task bus(input logic wr, input logic [4:0] a, output logic [31:0] q);
    int i;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= ZERO_WORD;
    avs_read      <= !wr;
    avs_write     <= wr;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      finish_test();
    end
  endtask : bus
  task fw(input logic [5:0] idx, input logic v);
    @(posedge sys_clk);
    fw_en  <= 1'b1;
    fw_idx <= idx;
    fw_val <= v;
    @(posedge sys_clk);
    fw_en  <= 1'b0;
  endtask : fw
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_reset;
    bus(0, ADDR_FUSE_LOW, d);
    chk("fuse_low", d, FUSE_SHIPPED);
    bus(0, ADDR_FUSE_HIGH, d);
    chk("fuse_high", d, ZERO_WORD);
    bus(0, ADDR_STATUS, d);
    chk("status", d, 32'h00006001);
    chk("bod_en", bod, 32'h3);
    chk("hyst", hyst, 32'h1);
    chk("level", lvl, 32'h3f);
    chk("boot", boot, 32'h3);
    chk("fetch", fetch, 32'h1);
    chk("locks", locks, 32'h0);
  endtask : t_reset
  task t_flags;
    @(posedge sys_clk);
    {cmd_busy, sec, blank, lwa, bce} <= 5'h1f;
    @(posedge sys_clk);
    {lwa, bce} <= 2'h0;
    bus(0, ADDR_STATUS, d);
    chk("status_set", d, 32'h0000603c);
    bus(0, ADDR_STATUS, d);
    chk("status_clr", d, 32'h00006030);
    {cmd_busy, sec, blank} <= 3'h0;
  endtask : t_flags
  task t_fuse;
    fw(6'h00, 1'b0);
    fw(6'h1c, 1'b0);
    fw(6'h28, 1'b0);
    fw(6'h1a, 1'b0);
    fw(6'h10, 1'b0);
    bus(0, ADDR_FUSE_LOW, d);
    chk("fuse_low", d, 32'hebf6fffe);
    chk("bod_en", bod, 32'h1);
    chk("hyst_prog", hyst, 32'h0);
    chk("fetch_prog", fetch, 32'h0);
    chk("locks", locks, 32'h1);
    bus(0, ADDR_STATUS, d);
    chk("status_locks", d[31:16], 32'h1);
    bus(0, ADDR_FUSE_HIGH, d);
    chk("fuse_high", d, ZERO_WORD);
  endtask : t_fuse
  task t_erase;
    int i;
    @(posedge sys_clk);
    jtag <= 1'b1;
    for (i = 0; i < 10 && !(bod === 2'h3 && locks === 16'h0); i++) @(posedge sys_clk);
    if (i == 10) begin
      n_mismatch++;
      finish_test();
    end
    bus(0, ADDR_FUSE_LOW, d);
    chk("jtag_erase", d, 32'hffffffff);
    jtag <= 1'b0;
    fw(6'h03, 1'b0);
    erase_all <= 1'b1;
    @(posedge sys_clk);
    erase_all <= 1'b0;
    bus(0, ADDR_FUSE_LOW, d);
    chk("erase_all", d, 32'hffffffff);
    // Registers are read-only and a hole reads zero
    bus(1, ADDR_FUSE_LOW, d);
    bus(1, ADDR_STATUS, d);
    bus(0, ADDR_FUSE_LOW, d);
    chk("ro_low", d, 32'hffffffff);
    bus(0, ADDR_STATUS, d);
    chk("ro_status", d, 32'h00006001);
    bus(0, 5'h00, d);
    chk("hole", d, ZERO_WORD);
  endtask : t_erase

  initial begin
    {avs_read, avs_write, cmd_busy, lwa, bce, sec, blank, fw_en, fw_val} = 9'h0;
    {erase_all, jtag} = 2'h0;
    avs_address   = 5'h00;
    avs_writedata = 32'hffffffff;
    fw_idx        = 6'h00;
    n_mismatch    = 0;
    checked       = 0;
    sys_rst       = 1'b1;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_flags();
    t_fuse();
    t_erase();
    finish_test();
  end
endmodule : fsf_status_fuse_tb
